/* File: rtl/pbc_regs.vh */
`ifndef PBC_REGS_VH
`define PBC_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PBC_ADDR_PORT_B_PINS_PINS 8'h00
`define PBC_ADDR_PORT_B_PINS_LAT 8'h04
`define PBC_ADDR_PORT_B_PINS_DIR 8'h08
`define PBC_ADDR_IRQ_MAIN 8'h0C
`define PBC_ADDR_IRQ_SECOND 8'h10
`define PBC_ADDR_IRQ_THIRD 8'h14
`define PBC_ADDR_PORT_C_PINS_PINS 8'h18
`define PBC_ADDR_PORT_C_PINS_LAT 8'h1C
`define PBC_ADDR_PORT_C_PINS_DIR 8'h20
`define PBC_ADDR_PERIPH_OVR 8'h24
`define PBC_ADDR_REG2REG 8'h28
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PBC_MAIN_FLAG_BIT 0
`define PBC_MAIN_ENABLE_BIT 3
`define PBC_SECOND_PRIO_BIT 0
`define PBC_SECOND_PULLUP_BIT 7
`define PBC_DIR_RESET 8'hFF
`define PBC_MAIN_RESET 8'h00
`define PBC_SECOND_RESET 8'hFF
`define PBC_THIRD_RESET 8'hC0
`define PBC_LAT_RESET 8'h00
`define PBC_CHANGE_MASK 8'hF0
`define PBC_RESP_OKAY 2'b00
`define PBC_RESP_SLVERR 2'b10
`endif

/* File: rtl/pbc_port_io.v */
// Summary of operation
// (RL1) direction 0 drives latch, 1 floats pin
// (RL2) latch register reads latch, not pins
// (RL3) port read gives pins, write sets latch
// (RL4) one active-low bit enables all pull-ups
// (RL5) output pins lose their pull-up
// (RL6) pull-ups off after power-on reset
// (RL7) bit 3 pull-up off while compare owns it
// (RL8) change detect upper four input pins only
// (RL9) compare against value captured at port read
// (RL10) mismatches ORed to set change flag
// (RL11) flag bit0, enable bit3, priority bit0
// (RL12) pull-up control at bit 7 second register
// (RL13) change interrupt wakes core from sleep
// (RL14) port access refreshes copy, move does not
// (RL15) persisting mismatch keeps setting flag
// (RL16) software should not poll during detection
// (RL17) port b pins feed ext irqs and capture
// (RL18) peripherals may force port c direction
// (RL19) override never written to direction reg
// (RL20) direction resets to ones on every reset
// (RL21) port c pins carry peripheral functions
// (RL22) pin inputs synchronised before use
//
// The address map and the AXI4-Lite register port were decided locally.
`include "pbc_regs.vh"
module pbc_port_io (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] AWADDR,
	input wire AWVALID,
	output reg AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output reg WREADY,
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	input wire [7:0] ARADDR,
	input wire ARVALID,
	output reg ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	input wire [7:0] PB_IN,
	output reg [7:0] PB_OUT,
	output reg [7:0] PB_OE,
	output reg [7:0] PB_PULLUP,
	input wire [7:0] PC_IN,
	output reg [7:0] PC_OUT,
	output reg [7:0] PC_OE,
	input wire [7:0] PC_PERIPH_OUT,
	input wire [7:0] PC_FORCE_OUT,
	input wire [7:0] PC_FORCE_IN,
	input wire [7:0] PC_PERIPH_EN,
	input wire CAPTURE_COMPARE_TWO_PIN_EN,
	input wire CAPTURE_COMPARE_TWO_OUT,
	input wire CAPTURE_COMPARE_TWO_DRIVE,
	output reg [2:0] EXT_IRQ_IN,
	output reg CAPTURE_COMPARE_TWO_IN,
	output reg [7:0] PC_PERIPH_IN,
	output reg CHANGE_IRQ,
	output reg CHANGE_IRQ_HIGH,
	output reg WAKE
);
// ----------------------------------------
// synchronisers and registers
// ----------------------------------------
reg [7:0] pb_s1_reg, pb_s2_reg, pc_s1_reg, pc_s2_reg;
reg [7:0] pb_lat_reg, pb_dir_reg, pc_lat_reg, pc_dir_reg;
reg [7:0] main_reg, second_reg, third_reg, snap_reg;
reg aw_got_reg, w_got_reg;
reg [7:0] aw_reg;
reg [31:0] w_reg;
reg [3:0] ws_reg;

always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		pb_s1_reg <= 8'h00;
		pb_s2_reg <= 8'h00;
		pc_s1_reg <= 8'h00;
		pc_s2_reg <= 8'h00;
	end else begin
		pb_s1_reg <= PB_IN; // RL22
		pb_s2_reg <= pb_s1_reg;
		pc_s1_reg <= PC_IN;
		pc_s2_reg <= pc_s1_reg;
	end
end

// ----------------------------------------
// bus handshake decode
// ----------------------------------------
wire wr_go = aw_got_reg && w_got_reg && !BVALID;
wire rd_go = ARVALID && ARREADY;
wire wsel = wr_go && ws_reg[0];
wire wr_pb = wsel && aw_reg == `PBC_ADDR_PORT_B_PINS_PINS;
wire wr_pbl = wsel && aw_reg == `PBC_ADDR_PORT_B_PINS_LAT;
wire wr_pc = wsel && aw_reg == `PBC_ADDR_PORT_C_PINS_PINS;
wire wr_pcl = wsel && aw_reg == `PBC_ADDR_PORT_C_PINS_LAT;
wire rd_pb = rd_go && ARADDR == `PBC_ADDR_PORT_B_PINS_PINS;
// move instruction path: same data, no snapshot refresh
wire rd_mv = rd_go && ARADDR == `PBC_ADDR_REG2REG;
wire wr_mv = wsel && aw_reg == `PBC_ADDR_REG2REG;
wire pb_touch = rd_pb || wr_pb; // RL14
wire [7:0] watch = ~pb_dir_reg & `PBC_CHANGE_MASK;
wire [7:0] mism = (pb_s2_reg ^ snap_reg) & ~watch & `PBC_CHANGE_MASK; // RL8
wire mismatch = |mism; // RL10
wire [7:0] pc_dir_eff = (pc_dir_reg & ~PC_FORCE_OUT) | PC_FORCE_IN; // RL18
wire [7:0] pb_oe_n = ~pb_dir_reg;
wire [7:0] pbwd = w_reg[7:0];

always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		aw_got_reg <= 1'b0;
		w_got_reg <= 1'b0;
		aw_reg <= 8'h00;
		w_reg <= 32'h0000_0000;
		ws_reg <= 4'h0;
		AWREADY <= 1'b0;
		WREADY <= 1'b0;
		BVALID <= 1'b0;
		BRESP <= `PBC_RESP_OKAY;
		ARREADY <= 1'b0;
		RVALID <= 1'b0;
		RDATA <= 32'h0000_0000;
		RRESP <= `PBC_RESP_OKAY;
	end else begin
		AWREADY <= !aw_got_reg && !AWREADY && !BVALID;
		WREADY <= !w_got_reg && !WREADY && !BVALID;
		if (AWVALID && AWREADY) begin
			aw_got_reg <= 1'b1;
			aw_reg <= AWADDR;
		end
		if (WVALID && WREADY) begin
			w_got_reg <= 1'b1;
			w_reg <= WDATA;
			ws_reg <= WSTRB;
		end
		if (wr_go) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			BVALID <= 1'b1;
			BRESP <= (aw_reg > `PBC_ADDR_REG2REG || aw_reg[1:0] != 2'b00)
				? `PBC_RESP_SLVERR : `PBC_RESP_OKAY;
		end else if (BVALID && BREADY) begin
			BVALID <= 1'b0;
		end
		ARREADY <= !ARREADY && !RVALID;
		if (rd_go) begin
			RVALID <= 1'b1;
			RRESP <= `PBC_RESP_OKAY;
			case (ARADDR)
			`PBC_ADDR_PORT_B_PINS_PINS: RDATA <= {24'h00_0000, pb_s2_reg}; // RL3
			`PBC_ADDR_REG2REG: RDATA <= {24'h00_0000, pb_s2_reg};
			`PBC_ADDR_PORT_B_PINS_LAT: RDATA <= {24'h00_0000, pb_lat_reg}; // RL2
			`PBC_ADDR_PORT_B_PINS_DIR: RDATA <= {24'h00_0000, pb_dir_reg};
			`PBC_ADDR_IRQ_MAIN: RDATA <= {24'h00_0000, main_reg};
			`PBC_ADDR_IRQ_SECOND: RDATA <= {24'h00_0000, second_reg};
			`PBC_ADDR_IRQ_THIRD: RDATA <= {24'h00_0000, third_reg};
			`PBC_ADDR_PORT_C_PINS_PINS: RDATA <= {24'h00_0000, pc_s2_reg};
			`PBC_ADDR_PORT_C_PINS_LAT: RDATA <= {24'h00_0000, pc_lat_reg};
			`PBC_ADDR_PORT_C_PINS_DIR: RDATA <= {24'h00_0000, pc_dir_reg}; // RL19
			`PBC_ADDR_PERIPH_OVR: RDATA <= {24'h00_0000, pc_dir_eff};
			default: begin
				RDATA <= 32'h0000_0000;
				RRESP <= `PBC_RESP_SLVERR;
			end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end
end

// ----------------------------------------
// port registers
// ----------------------------------------
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		pb_lat_reg <= `PBC_LAT_RESET;
		pc_lat_reg <= `PBC_LAT_RESET;
		pb_dir_reg <= `PBC_DIR_RESET; // RL20
		pc_dir_reg <= `PBC_DIR_RESET; // RL20
		main_reg <= `PBC_MAIN_RESET;
		second_reg <= `PBC_SECOND_RESET; // RL6
		third_reg <= `PBC_THIRD_RESET;
		snap_reg <= 8'h00;
	end else begin
		if (wr_pb || wr_pbl || wr_mv)
			pb_lat_reg <= pbwd; // RL3
		if (wr_pc || wr_pcl)
			pc_lat_reg <= pbwd;
		if (wsel && aw_reg == `PBC_ADDR_PORT_B_PINS_DIR)
			pb_dir_reg <= pbwd;
		if (wsel && aw_reg == `PBC_ADDR_PORT_C_PINS_DIR)
			pc_dir_reg <= pbwd;
		if (wsel && aw_reg == `PBC_ADDR_IRQ_SECOND)
			second_reg <= pbwd; // RL12
		if (wsel && aw_reg == `PBC_ADDR_IRQ_THIRD)
			third_reg <= pbwd;
		if (pb_touch)
			snap_reg <= pb_s2_reg; // RL9
		if (wsel && aw_reg == `PBC_ADDR_IRQ_MAIN)
			main_reg <= pbwd;
		// set beats clear while mismatch lasts, except in a cycle with a port access
		if (mismatch && !pb_touch)
			main_reg[`PBC_MAIN_FLAG_BIT] <= 1'b1; // RL15
	end
end

// ----------------------------------------
// pin drive, pull-ups and interrupt outputs
// ----------------------------------------
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		PB_OUT <= 8'h00;
		PB_OE <= 8'h00;
		PB_PULLUP <= 8'h00;
		PC_OUT <= 8'h00;
		PC_OE <= 8'h00;
		EXT_IRQ_IN <= 3'b000;
		CAPTURE_COMPARE_TWO_IN <= 1'b0;
		PC_PERIPH_IN <= 8'h00;
		CHANGE_IRQ <= 1'b0;
		CHANGE_IRQ_HIGH <= 1'b0;
		WAKE <= 1'b0;
	end else begin
		PB_OUT <= {pb_lat_reg[7:4],
			CAPTURE_COMPARE_TWO_PIN_EN ? CAPTURE_COMPARE_TWO_OUT : pb_lat_reg[3],
			pb_lat_reg[2:0]}; // RL1
		PB_OE <= {pb_oe_n[7:4],
			CAPTURE_COMPARE_TWO_PIN_EN ? CAPTURE_COMPARE_TWO_DRIVE : pb_oe_n[3],
			pb_oe_n[2:0]}; // RL1
		PB_PULLUP <= {8{~second_reg[`PBC_SECOND_PULLUP_BIT]}} // RL4
			& pb_dir_reg // RL5
			& {4'hF, ~CAPTURE_COMPARE_TWO_PIN_EN, 3'b111}; // RL7
		PC_OUT <= (PC_PERIPH_EN & PC_PERIPH_OUT)
			| (~PC_PERIPH_EN & pc_lat_reg); // RL21
		PC_OE <= ~pc_dir_eff; // RL18
		EXT_IRQ_IN <= pb_s2_reg[2:0]; // RL17
		CAPTURE_COMPARE_TWO_IN <= pb_s2_reg[3]; // RL17
		PC_PERIPH_IN <= pc_s2_reg; // RL21
		CHANGE_IRQ <= main_reg[`PBC_MAIN_FLAG_BIT]
			& main_reg[`PBC_MAIN_ENABLE_BIT]; // RL11
		CHANGE_IRQ_HIGH <= second_reg[`PBC_SECOND_PRIO_BIT]; // RL11
		WAKE <= main_reg[`PBC_MAIN_FLAG_BIT]
			& main_reg[`PBC_MAIN_ENABLE_BIT]; // RL13
	end
end

endmodule

/* File: verif/pbc_checker.sv */
module pbc_checker (
	input wire CLK,
	input wire RST_N,
	input wire AWREADY,
	input wire WREADY,
	input wire BVALID,
	input wire BREADY,
	input wire ARREADY,
	input wire RVALID,
	input wire RREADY,
	input wire [31:0] RDATA,
	input wire [7:0] PB_OE,
	input wire [7:0] PB_PULLUP,
	input wire CAPTURE_COMPARE_TWO_PIN_EN,
	input wire [7:0] PC_FORCE_IN,
	input wire [7:0] PC_OE,
	input wire CHANGE_IRQ,
	input wire WAKE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	pull_off_a: assert property (!(PB_PULLUP & PB_OE))
		else $error("pull-up on output");
	ccp_pull_a: assert property ($past(CAPTURE_COMPARE_TWO_PIN_EN) |-> !PB_PULLUP[3])
		else $error("pull-up on compare pin");
	wake_irq_a: assert property (WAKE == CHANGE_IRQ)
		else $error("wake differs");
	force_in_a: assert property ($past(PC_FORCE_IN) == 8'hff |-> !PC_OE)
		else $error("forced input driven");
	b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
		else $error("response dropped");
	r_hold_a: assert property (RVALID && !RREADY |=> $stable(RDATA))
		else $error("read data moved");
	b_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while busy");
	r_busy_a: assert property (RVALID |-> !ARREADY)
		else $error("read taken while busy");
	cover property (CHANGE_IRQ);
	cover property (BVALID && BREADY);
	cover property (RVALID && RREADY);
	cover property (WAKE);
endmodule

/* File: verif/pbc_keypad.sv */
module pbc_keypad (
	input wire clk,
	input wire [7:0] pb_out,
	input wire [7:0] pb_oe,
	input wire [7:0] pb_pullup,
	input wire [7:0] key_down,
	output wire [7:0] pb_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] noise_reg = 8'h5a;
	always @(posedge clk)
		noise_reg <= ~noise_reg;
	// a key shorts to ground; a pin nobody holds wanders
	assign pb_in = pb_oe & pb_out
		| ~pb_oe & ~key_down & (pb_pullup | noise_reg);
endmodule

/* File: verif/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 1'b0, RST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0;
	logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, CAPTURE_COMPARE_TWO_OUT = 1'b0;
	logic CAPTURE_COMPARE_TWO_PIN_EN = 1'b0, CAPTURE_COMPARE_TWO_DRIVE = 1'b0, AWREADY, WREADY, BVALID;
	logic ARREADY, RVALID, CHANGE_IRQ, CHANGE_IRQ_HIGH, WAKE, CAPTURE_COMPARE_TWO_IN;
	logic [1:0] BRESP, RRESP;
	logic [2:0] EXT_IRQ_IN;
	logic [3:0] WSTRB = 4'hf;
	logic [7:0] AWADDR = '0, ARADDR = '0, PC_IN = '0, PC_PERIPH_OUT = '0;
	logic [7:0] PC_FORCE_OUT = '0, PC_FORCE_IN = '0, PC_PERIPH_EN = '0;
	logic [7:0] PB_IN, PB_OUT, PB_OE, PB_PULLUP, PC_OUT, PC_OE, PC_PERIPH_IN;
	logic [7:0] keys = '0, v;
	logic [9:0] got;
	logic [31:0] WDATA = '0, RDATA;
	int err_count = 0, comparisons = 0, seed = 32'hcfe1;
	pbc_port_io u_dut (.*);
	pbc_keypad u_keys (.clk(CLK), .pb_out(PB_OUT), .pb_oe(PB_OE),
		.pb_pullup(PB_PULLUP), .key_down(keys), .pb_in(PB_IN));
	always #50 CLK = ~CLK;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= {24'h00_0000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (!(BVALID && BREADY)) begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (!BREADY) BREADY <= BVALID;
		end
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		while (!(RVALID && RREADY)) begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (!RREADY) RREADY <= RVALID;
		end
		got = {RRESP, RDATA[7:0]};
		RREADY <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] x);
		rd(a);
		chk(got, {2'b00, x});
	endtask
	task close_out;
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#1ms;
		err_count++;
		close_out;
	end
	initial begin
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		// first read lands before any synced pin can set the flag
		rdc(8'h0c, 8'h00);
		rdc(8'h08, 8'hff);
		rdc(8'h20, 8'hff);
		rdc(8'h10, 8'hff);
		rdc(8'h14, 8'hc0);
		chk(PB_PULLUP, 8'h00);
		wr(8'h08, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			PC_IN <= v;
			wr(8'h00, v);
			wr(8'h1c, ~v);
			repeat (4) @(posedge CLK);
			chk({PB_OE, PB_OUT, PC_OE}, {8'hff, v, 8'h00});
			rdc(8'h00, v);
			rdc(8'h1c, ~v);
			rdc(8'h18, v);
		end
		wr(8'h08, 8'h7f);
		wr(8'h10, 8'h7f);
		repeat (4) @(posedge CLK);
		chk({PB_PULLUP, CHANGE_IRQ_HIGH}, {8'h7f, 1'b1});
		CAPTURE_COMPARE_TWO_PIN_EN <= 1'b1;
		keys <= 8'h01;
		repeat (4) @(posedge CLK);
		chk({PB_PULLUP, EXT_IRQ_IN}, {8'h77, 3'b110});
		wr(8'h0c, 8'h08);
		rd(8'h00);
		wr(8'h0c, 8'h08);
		wr(8'h04, {~v[7], 7'h00});
		keys <= 8'h00;
		repeat (6) @(posedge CLK);
		chk(CHANGE_IRQ, 1'b0);
		// wake on key press, no polling of the port meanwhile
		keys <= 8'h20;
		repeat (6) @(posedge CLK);
		chk(CHANGE_IRQ, 1'b1);
		chk(WAKE, 1'b1);
		for (int i = 0; i < 3; i++) begin
			if (i > 0) rd(i == 1 ? 8'h28 : 8'h00);
			wr(8'h0c, 8'h08);
			rdc(8'h0c, i == 2 ? 8'h08 : 8'h09);
		end
		PC_PERIPH_OUT <= v;
		PC_PERIPH_EN <= 8'hff;
		PC_FORCE_OUT <= 8'hff;
		repeat (4) @(posedge CLK);
		chk({PC_OE, PC_OUT}, {8'hff, v});
		rdc(8'h20, 8'hff);
		PC_FORCE_IN <= 8'hff;
		repeat (4) @(posedge CLK);
		chk(PC_OE, 8'h00);
		rd(8'h2c);
		chk(got, 10'h200);
		close_out;
	end
endmodule
bind pbc_port_io pbc_checker u_chk (.*);
